/* File: verilog/pss_pkg.sv */
package pss_pkg;

    // ------------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------------
    localparam int          CLK_MHZ            = 100;
    localparam int          TICK_US            = 1000;                   // Timer base unit is 1 ms
    localparam int          TICK_CYCLES        = TICK_US * CLK_MHZ;      // Cycles per timer unit
    localparam logic [31:0] TICK_LAST          = 32'(TICK_CYCLES - 1);

    // ------------------------------------------------------------------
    // Setting encodings
    // ------------------------------------------------------------------
    localparam logic [15:0] CLAMP_USE_LIMITER  = 16'h03E7;               // Clamp value 999 selects limiter
    localparam logic [7:0]  SCHEME_FIXED_LOOP  = 8'h01;
    localparam logic [7:0]  SCHEME_FIXED_FREQ  = 8'h0B;
    localparam logic [7:0]  SCHEME_FLOAT_LOOP  = 8'h02;
    localparam logic [7:0]  SCHEME_FLOAT_FREQ  = 8'h0C;
    localparam logic [7:0]  SCHEME_REDUCE_LOOP = 8'h03;
    localparam logic [7:0]  SCHEME_REDUCE_FREQ = 8'h0D;
    localparam logic [7:0]  SCHEME_LINK_CYCLE  = 8'h34;
    localparam logic [7:0]  SCHEME_LINK_ALL    = 8'h36;
    localparam logic [2:0]  FIXED_MAINS_MAX    = 3'h4;
    localparam logic [2:0]  FLOAT_MAINS_MAX    = 3'h2;
    localparam logic [2:0]  FLOAT_MOTORS_MAX   = 3'h3;
    localparam logic [2:0]  REDUCE_MOTORS_MAX  = 3'h5;
    localparam logic [2:0]  LINK_DRIVES_MAX    = 3'h4;
    localparam logic [2:0]  FLOAT_CONTACTORS   = 3'h5;                   // Two per floating pump plus one

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0]  REG_CTRL           = 8'h00;
    localparam logic [7:0]  REG_SLEEP          = 8'h04;
    localparam logic [7:0]  REG_WAKE           = 8'h08;
    localparam logic [7:0]  REG_CLAMP          = 8'h0C;
    localparam logic [7:0]  REG_LIMIT          = 8'h10;
    localparam logic [7:0]  REG_DEW            = 8'h14;
    localparam logic [7:0]  REG_STATUS         = 8'h18;
    localparam logic [7:0]  REG_IRQ_STAT       = 8'h1C;
    localparam logic [7:0]  REG_IRQ_MASK       = 8'h20;
    localparam logic [7:0]  REG_PLAN          = 8'h24;

    // Reset values
    localparam logic [31:0] RST_CTRL           = 32'h0000_0000;
    localparam logic [31:0] RST_CLAMP          = 32'h03E7_03E7;
    localparam logic [31:0] RST_ZERO           = 32'h0000_0000;
    localparam int          IRQ_BITS           = 3;                      // Sleep entry, wake, dew start

    // Decoded pump plan shown to the contactor side
    typedef struct packed {
        logic [2:0] mainsMax;
        logic [2:0] motorsMax;
        logic [2:0] contactors;
        logic       auxPump;
        logic       judgeOnFreq;
        logic       linked;
        logic       allSameSpeed;
        logic       cycleOrder;
    } pss_plan_t;

    // Loop sample from the PID processor
    typedef struct packed {
        logic [15:0] loopOut;
        logic [15:0] outFreq;
        logic [15:0] feedback;
        logic [15:0] setpoint;
    } pss_loop_t;

endpackage : pss_pkg

/* File: verilog/pss_hold_timer.sv */
// Counts whole ticks while a condition holds; any lapse restarts from zero
module pss_hold_timer (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        tick,
    input  wire logic        cond,
    input  wire logic [15:0] limit,
    output logic             expired
);
    import pss_pkg::*;

    logic [15:0] countFf;

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            countFf <= 16'h0000;
        end else if (!cond) begin
            countFf <= 16'h0000;
        end else if (tick && countFf != 16'hFFFF) begin
            countFf <= countFf + 16'h0001;
        end
    end

    assign expired = cond && (countFf >= limit);

endmodule : pss_hold_timer

/* File: verilog/pss_top.sv */
module pss_top (
    input  wire logic              mclk,
    input  wire logic              resetn,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hsel,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire pss_pkg::pss_loop_t loopIn,
    input  wire logic [15:0]       presetRef,
    input  wire logic              runCmd,
    input  wire logic              condensationGuardInput,
    input  wire logic              loopBypassCommand,
    output logic [15:0]            freqRef,
    output logic                   motorRun,
    output logic                   dcInject,
    output logic [15:0]            dcLevel,
    output logic                   sleepStateOutput,
    output pss_pkg::pss_plan_t     planOut,
    output logic                   irq
);
    import pss_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers (external inputs)
    // ------------------------------------------------------------------
    logic [2:0] syncAFf;
    logic [2:0] syncBFf;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            syncAFf <= 3'h0;
            syncBFf <= 3'h0;
        end else begin
            syncAFf <= {runCmd, condensationGuardInput, loopBypassCommand};
            syncBFf <= syncAFf;
        end
    end
    logic runS, guardS, bypassS;
    assign runS    = syncBFf[2];
    assign guardS  = syncBFf[1];
    assign bypassS = syncBFf[0];

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [31:0] ctrlFf, sleepFf, wakeFf, clampFf, limitFf, dewFf, maskFf;
    logic [IRQ_BITS-1:0] istatFf;
    logic [15:0] sleepFreq, sleepDelay, wakeFreq, wakeDelay, wakeErr;
    assign sleepFreq  = sleepFf[15:0];
    assign sleepDelay = sleepFf[31:16];
    assign wakeFreq   = wakeFf[15:0];
    assign wakeDelay  = wakeFf[31:16];
    assign wakeErr    = ctrlFf[31:16];
    logic [7:0] scheme;
    assign scheme = ctrlFf[7:0];

    // AHB-Lite address phase capture
    logic        wrPendFf;
    logic [7:0]  addrFf;
    logic        acc;
    assign acc = hsel && hready && htrans[1];
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wrPendFf <= 1'b0;
            addrFf   <= 8'h00;
        end else begin
            wrPendFf <= acc && hwrite;
            if (acc) begin
                addrFf <= haddr[7:0];
            end
        end
    end

    // Zero wait states; every access answers OKAY
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Writable settings
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctrlFf  <= RST_CTRL;
            sleepFf <= RST_ZERO;
            wakeFf  <= RST_ZERO;
            clampFf <= RST_CLAMP;
            limitFf <= RST_ZERO;
            dewFf   <= RST_ZERO;
            maskFf  <= RST_ZERO;
        end else if (wrPendFf) begin
            case (addrFf)
                REG_CTRL:     ctrlFf  <= hwdata;
                REG_SLEEP:    sleepFf <= hwdata;
                REG_WAKE:     wakeFf  <= hwdata;
                REG_CLAMP:    clampFf <= hwdata;
                REG_LIMIT:    limitFf <= hwdata;
                REG_DEW:      dewFf   <= hwdata;
                REG_IRQ_MASK: maskFf  <= {29'h0, hwdata[2:0]};
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------------
    logic [31:0] preFf;
    logic        tickFf;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            preFf  <= 32'h0;
            tickFf <= 1'b0;
        end else begin
            tickFf <= (preFf == TICK_LAST);
            preFf  <= (preFf == TICK_LAST) ? 32'h0 : preFf + 32'h1;
        end
    end

    // ------------------------------------------------------------------
    // Sleep and wake supervision
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {ST_STOP, ST_RUN, ST_SLEEP, ST_DEW} pss_state_t;
    pss_state_t stateFf;

    logic [15:0] sleepLevel, errAbs;
    logic sleepCond, wakeFreqOk, wakeErrOk, sleepExp, wakeFreqExp, wakeErrExp;
    assign sleepLevel = (wakeFreq < sleepFreq) ? wakeFreq : sleepFreq;
    assign sleepCond  = (stateFf == ST_RUN) && !bypassS && (loopIn.loopOut < sleepLevel);
    assign wakeFreqOk = (stateFf == ST_SLEEP) && (loopIn.loopOut >= wakeFreq);
    assign errAbs     = (loopIn.feedback >= loopIn.setpoint) ? loopIn.feedback - loopIn.setpoint
                                                             : loopIn.setpoint - loopIn.feedback;
    assign wakeErrOk  = (stateFf == ST_SLEEP) && (errAbs >= wakeErr);

    pss_hold_timer uSleepTmr (.mclk(mclk), .resetn(resetn), .tick(tickFf), .cond(sleepCond),
                              .limit(sleepDelay), .expired(sleepExp));
    pss_hold_timer uWakeFTmr (.mclk(mclk), .resetn(resetn), .tick(tickFf), .cond(wakeFreqOk),
                              .limit(wakeDelay), .expired(wakeFreqExp));
    pss_hold_timer uWakeETmr (.mclk(mclk), .resetn(resetn), .tick(tickFf), .cond(wakeErrOk),
                              .limit(wakeDelay), .expired(wakeErrExp));

    // ------------------------------------------------------------------
    // Dew condensation duty counter
    // ------------------------------------------------------------------
    logic [15:0] dewCntFf, dewOn, dewPeriod;
    assign dewPeriod = dewFf[15:0];                                  // Duty cycle period in ticks
    assign dewOn     = 16'((32'(dewPeriod) * 32'(dewFf[23:16])) / 32'd100);
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            dewCntFf <= 16'h0000;
        end else if (stateFf != ST_DEW) begin
            dewCntFf <= 16'h0000;
        end else if (tickFf) begin
            dewCntFf <= (dewCntFf + 16'h0001 >= dewPeriod) ? 16'h0000 : dewCntFf + 16'h0001;
        end
    end

    // State machine
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            stateFf <= ST_STOP;
        end else begin
            case (stateFf)
                ST_STOP: begin
                    if (runS) stateFf <= ST_RUN;
                    else if (guardS) stateFf <= ST_DEW;
                end
                ST_RUN: begin
                    if (!runS) stateFf <= ST_STOP;
                    else if (sleepExp) stateFf <= ST_SLEEP;
                end
                ST_SLEEP: begin
                    if (!runS) stateFf <= ST_STOP;
                    else if (wakeFreqExp && wakeErrExp) stateFf <= ST_RUN;
                end
                ST_DEW: begin
                    if (runS || !guardS) stateFf <= ST_STOP;
                end
                default: stateFf <= ST_STOP;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Output clamp and drive outputs
    // ------------------------------------------------------------------
    logic [15:0] upLim, loLim, clamped;
    assign upLim = (clampFf[15:0] == CLAMP_USE_LIMITER) ? limitFf[15:0] : clampFf[15:0];
    assign loLim = (clampFf[31:16] == CLAMP_USE_LIMITER) ? limitFf[31:16] : clampFf[31:16];
    assign clamped = (loopIn.loopOut > upLim) ? upLim :
                     (loopIn.loopOut < loLim) ? loLim : loopIn.loopOut;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            freqRef          <= 16'h0000;
            motorRun         <= 1'b0;
            dcInject         <= 1'b0;
            dcLevel          <= 16'h0000;
            sleepStateOutput <= 1'b0;
        end else begin
            freqRef          <= bypassS ? presetRef : clamped;
            motorRun         <= (stateFf == ST_RUN);
            dcInject         <= (stateFf == ST_DEW) && (dewCntFf < dewOn);
            dcLevel          <= (stateFf == ST_DEW) ? dewFf[31:24] * 16'h0001 : 16'h0000;
            sleepStateOutput <= (stateFf == ST_SLEEP);
        end
    end

    // ------------------------------------------------------------------
    // Pump scheme decode
    // ------------------------------------------------------------------
    pss_plan_t nxt_plan;
    always_comb begin
        nxt_plan = '0;
        case (scheme)
            SCHEME_FIXED_LOOP, SCHEME_FIXED_FREQ: begin
                nxt_plan.mainsMax    = FIXED_MAINS_MAX;
                nxt_plan.motorsMax   = 3'(FIXED_MAINS_MAX + 3'h1);
                nxt_plan.contactors  = FIXED_MAINS_MAX;
                nxt_plan.auxPump     = 1'b1;
                nxt_plan.judgeOnFreq = (scheme == SCHEME_FIXED_FREQ);
            end
            SCHEME_FLOAT_LOOP, SCHEME_FLOAT_FREQ: begin
                nxt_plan.mainsMax    = FLOAT_MAINS_MAX;
                nxt_plan.motorsMax   = FLOAT_MOTORS_MAX;
                nxt_plan.contactors  = FLOAT_CONTACTORS;
                nxt_plan.auxPump     = 1'b1;
                nxt_plan.judgeOnFreq = (scheme == SCHEME_FLOAT_FREQ);
            end
            SCHEME_REDUCE_LOOP, SCHEME_REDUCE_FREQ: begin
                nxt_plan.mainsMax    = FLOAT_MAINS_MAX;
                nxt_plan.motorsMax   = REDUCE_MOTORS_MAX;
                nxt_plan.contactors  = FLOAT_CONTACTORS;
                nxt_plan.auxPump     = 1'b1;
                nxt_plan.judgeOnFreq = (scheme == SCHEME_REDUCE_FREQ);
            end
            SCHEME_LINK_CYCLE: begin
                nxt_plan.motorsMax  = LINK_DRIVES_MAX;
                nxt_plan.linked     = 1'b1;
                nxt_plan.cycleOrder = 1'b1;
            end
            SCHEME_LINK_ALL: begin
                nxt_plan.motorsMax    = LINK_DRIVES_MAX;
                nxt_plan.linked       = 1'b1;
                nxt_plan.allSameSpeed = 1'b1;
            end
            default: nxt_plan = '0;
        endcase
    end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            planOut <= '0;
        end else begin
            planOut <= nxt_plan;
        end
    end

    // ------------------------------------------------------------------
    // Interrupts: sleep entry, wake, dew start; set wins over clear
    // ------------------------------------------------------------------
    pss_state_t prevFf;
    logic [IRQ_BITS-1:0] evt, clr;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) prevFf <= ST_STOP;
        else prevFf <= stateFf;
    end
    assign evt = {(stateFf == ST_DEW && prevFf != ST_DEW),
                  (stateFf == ST_RUN && prevFf == ST_SLEEP),
                  (stateFf == ST_SLEEP && prevFf != ST_SLEEP)};
    assign clr = (wrPendFf && addrFf == REG_IRQ_STAT) ? hwdata[2:0] : 3'h0;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            istatFf <= 3'h0;
            irq     <= 1'b0;
        end else begin
            istatFf <= (istatFf & ~clr) | evt;
            irq     <= |(istatFf & maskFf[2:0]);
        end
    end

    // Read data
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hrdata <= 32'h0;
        end else if (acc && !hwrite) begin
            case (haddr[7:0])
                REG_CTRL:     hrdata <= ctrlFf;
                REG_SLEEP:    hrdata <= sleepFf;
                REG_WAKE:     hrdata <= wakeFf;
                REG_CLAMP:    hrdata <= clampFf;
                REG_LIMIT:    hrdata <= limitFf;
                REG_DEW:      hrdata <= dewFf;
                REG_STATUS:   hrdata <= {30'h0, stateFf};
                REG_IRQ_STAT: hrdata <= {29'h0, istatFf};
                REG_IRQ_MASK: hrdata <= maskFf;
                REG_PLAN:     hrdata <= {18'h0, planOut};
                default:      hrdata <= 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sleep_out_a: assert property (@(posedge mclk) disable iff (!resetn)
        sleepStateOutput == ($past(stateFf) == ST_SLEEP)) else $error("sleep output wrong");
    bypass_ref_a: assert property (@(posedge mclk) disable iff (!resetn)
        $past(bypassS) |-> freqRef == $past(presetRef)) else $error("bypass ref wrong");
    clamp_up_a: assert property (@(posedge mclk) disable iff (!resetn)
        !$past(bypassS) && $past(loLim) <= $past(upLim) |-> freqRef <= $past(upLim))
        else $error("upper clamp broken");
    clamp_lo_a: assert property (@(posedge mclk) disable iff (!resetn)
        !$past(bypassS) && $past(loLim) <= $past(upLim) |-> freqRef >= $past(loLim))
        else $error("lower clamp broken");
    sleep_entry_a: assert property (@(posedge mclk) disable iff (!resetn)
        stateFf == ST_RUN ##1 stateFf == ST_SLEEP |-> $past(sleepExp)) else $error("early sleep");
    wake_exit_a: assert property (@(posedge mclk) disable iff (!resetn)
        stateFf == ST_SLEEP ##1 stateFf == ST_RUN |-> $past(wakeFreqExp && wakeErrExp))
        else $error("early wake");
    dew_start_a: assert property (@(posedge mclk) disable iff (!resetn)
        stateFf == ST_STOP ##1 stateFf == ST_DEW |-> $past(guardS) && !$past(runS))
        else $error("dew start wrong");
    dew_duty_a: assert property (@(posedge mclk) disable iff (!resetn)
        dcInject |-> $past(dewCntFf) < $past(dewOn)) else $error("dew duty wrong");

endmodule : pss_top

/* File: verif/pss_motor_model.sv */
// Far side of the drive: loop processor samples, condensation guard pin, motor
module pss_motor_model (
    input  wire logic               mclk,
    input  wire logic               guardReq,
    input  wire pss_pkg::pss_loop_t loopReq,
    input  wire logic               motorRun,
    input  wire logic               dcInject,
    output pss_pkg::pss_loop_t      loopIn,
    output logic                    condensationGuardInput,
    output logic [15:0]             dcPulses
);
    timeunit 1ns;
    timeprecision 100ps;
    import pss_pkg::*;

    logic dcInjectPrev;

    initial begin
        loopIn = '0;
        condensationGuardInput = 1'b0;
        dcPulses = 16'h0000;
        dcInjectPrev = 1'b0;
    end

    // ------------------------------------------------------------------
    // Pin behaviour
    // ------------------------------------------------------------------
    // Guard only raised while the motor is at rest; a running motor drops it
    always @(posedge mclk) begin
        loopIn <= loopReq;
        condensationGuardInput <= guardReq & ~motorRun;
        dcInjectPrev <= dcInject;
        if (dcInject & ~dcInjectPrev) begin
            dcPulses <= dcPulses + 16'h0001;
        end
    end
endmodule : pss_motor_model

/* File: verif/test_pid_sleep_wakeup_pump_staging.sv */
module test_pid_sleep_wakeup_pump_staging;
    timeunit 1ns;
    timeprecision 100ps;
    import pss_pkg::*;

    logic        mclk = 1'b0, resetn = 1'b0, hwrite = 1'b0, hsel = 1'b0, hreadyout, hresp;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0]  htrans = 2'h0;
    logic [15:0] presetRef = 16'h0000, freqRef, dcLevel, dcPulses;
    logic        runCmd = 1'b0, guardReq = 1'b0, loopBypassCommand = 1'b0, guardPin;
    logic        motorRun, dcInject, sleepStateOutput, irq;
    pss_loop_t   loopReq = '0, loopIn;
    pss_plan_t   planOut;
    int          numErrors = 0, comparisons = 0;
    logic [7:0]  codes [8] = '{8'h01, 8'h0B, 8'h02, 8'h0C, 8'h03, 8'h0D, 8'h34, 8'h36};

    always #5 mclk = ~mclk;

    pss_top DUT (.mclk(mclk), .resetn(resetn), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hsel(hsel), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .loopIn(loopIn), .presetRef(presetRef),
        .runCmd(runCmd), .condensationGuardInput(guardPin), .loopBypassCommand(loopBypassCommand),
        .freqRef(freqRef), .motorRun(motorRun), .dcInject(dcInject), .dcLevel(dcLevel),
        .sleepStateOutput(sleepStateOutput), .planOut(planOut), .irq(irq));

    pss_motor_model farSide (.mclk(mclk), .guardReq(guardReq), .loopReq(loopReq),
        .motorRun(motorRun), .dcInject(dcInject), .loopIn(loopIn),
        .condensationGuardInput(guardPin), .dcPulses(dcPulses));

    // ------------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------------
    task automatic giveVerdict();
        if (numErrors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : giveVerdict

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            numErrors++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Bounded wait for hready; a stuck slave ends the run as a failure
    task automatic waitReady();
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            numErrors++;
            giveVerdict();
        end
    endtask : waitReady

    // ------------------------------------------------------------------
    // AHB-Lite single word transfer: address phase, then data phase
    // ------------------------------------------------------------------
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsel   <= 1'b1;
        waitReady();
        htrans <= 2'h0;
        hwdata <= d;
        waitReady();
        rd = hrdata;
    endtask : bus

    task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(nm, exp, rd);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : rdChk

    // Drive the loop output, allow sync and register stages, compare reference
    task automatic clampChk(input logic [15:0] lo, input logic [15:0] exp);
        loopReq.loopOut <= lo;
        repeat (6) @(posedge mclk);
        chk("freqRef", {16'h0, exp}, {16'h0, freqRef});
    endtask : clampChk

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        rdChk("ctrl", REG_CTRL, RST_CTRL);
        rdChk("clamp", REG_CLAMP, RST_CLAMP);
        rdChk("status", REG_STATUS, 32'h0);
        rdChk("unmapped", 8'h3C, 32'h0);
        // Explicit clamps, then 999 falls back to the frequency limiters
        bus(1'b1, REG_LIMIT, 32'h012C_02BC);
        bus(1'b1, REG_CLAMP, 32'h00C8_0320);
        clampChk(16'd900, 16'd800);
        clampChk(16'd100, 16'd200);
        clampChk(16'd500, 16'd500);
        bus(1'b1, REG_CLAMP, RST_CLAMP);
        clampChk(16'd900, 16'd700);
        clampChk(16'd100, 16'd300);
        // Bypass ignores clamps and runs on the preset reference
        presetRef <= 16'd950;
        loopBypassCommand <= 1'b1;
        clampChk(16'd100, 16'd950);
        loopBypassCommand <= 1'b0;
        clampChk(16'd100, 16'd300);
        // Pump scheme decoding, one pass over every mode
        foreach (codes[i]) begin
            bus(1'b1, REG_CTRL, {24'h0, codes[i]});
            repeat (3) @(posedge mclk);
            if (i < 6) begin
                chk("judgeOnFreq", {31'h0, i[0]}, {31'h0, planOut.judgeOnFreq});
                chk("auxPump", 32'h1, {31'h0, planOut.auxPump});
                chk("linked", 32'h0, {31'h0, planOut.linked});
            end
            if (i < 2) chk("mainsMax", 32'h4, {29'h0, planOut.mainsMax});
            if (i == 2 || i == 3) begin
                chk("motorsMax", 32'h3, {29'h0, planOut.motorsMax});
                chk("contactors", 32'h5, {29'h0, planOut.contactors});
            end
            if (i == 4 || i == 5) chk("motorsMax", 32'h5, {29'h0, planOut.motorsMax});
            if (i >= 6) begin
                chk("linked", 32'h1, {31'h0, planOut.linked});
                chk("cycleOrder", {31'h0, ~i[0]}, {31'h0, planOut.cycleOrder});
                chk("allSameSpeed", {31'h0, i[0]}, {31'h0, planOut.allSameSpeed});
            end
        end
        rdChk("plan", REG_PLAN, 32'h0000_0406);
        // Condensation guard while stopped: dew mode, DC level, interrupt
        bus(1'b1, REG_DEW, 32'h5A32_0002);
        guardReq <= 1'b1;
        repeat (8) @(posedge mclk);
        chk("dcLevel", 32'h5A, {16'h0, dcLevel});
        chk("dcInject", 32'h1, {31'h0, dcInject});
        chk("dcPulses", 32'h1, {16'h0, dcPulses});
        chk("sleepOut", 32'h0, {31'h0, sleepStateOutput});
        rdChk("status", REG_STATUS, 32'h3);
        rdChk("irqStat", REG_IRQ_STAT, 32'h4);
        chk("irqMasked", 32'h0, {31'h0, irq});
        bus(1'b1, REG_IRQ_MASK, 32'h4);
        repeat (2) @(posedge mclk);
        chk("irq", 32'h1, {31'h0, irq});
        bus(1'b1, REG_IRQ_STAT, 32'h4);
        repeat (2) @(posedge mclk);
        chk("irqCleared", 32'h0, {31'h0, irq});
        rdChk("irqStat", REG_IRQ_STAT, 32'h0);
        guardReq <= 1'b0;
        // Sleep under the sleep level; wake only when both wake conditions hold
        bus(1'b1, REG_SLEEP, 32'h0000_0190);
        bus(1'b1, REG_WAKE, 32'h0000_0258);
        bus(1'b1, REG_CTRL, 32'h0010_0036);
        loopReq.loopOut <= 16'd500;
        runCmd <= 1'b1;
        repeat (8) @(posedge mclk);
        chk("motorRun", 32'h1, {31'h0, motorRun});
        loopReq.loopOut <= 16'd300;
        repeat (8) @(posedge mclk);
        chk("motorRunSleep", 32'h0, {31'h0, motorRun});
        chk("sleepOut", 32'h1, {31'h0, sleepStateOutput});
        loopReq.loopOut <= 16'd700;
        repeat (8) @(posedge mclk);
        rdChk("status", REG_STATUS, 32'h2);
        loopReq.feedback <= 16'h0040;
        repeat (8) @(posedge mclk);
        rdChk("status", REG_STATUS, 32'h1);
        chk("sleepOut", 32'h0, {31'h0, sleepStateOutput});
        rdChk("irqStat", REG_IRQ_STAT, 32'h3);
        // A dip shorter than a one-tick delay keeps running; a low wake level moves the sleep level
        bus(1'b1, REG_SLEEP, 32'h0001_0190);
        loopReq.loopOut <= 16'd300;
        repeat (8) @(posedge mclk);
        rdChk("status", REG_STATUS, 32'h1);
        bus(1'b1, REG_WAKE, 32'h0000_00C8);
        bus(1'b1, REG_SLEEP, 32'h0000_0190);
        repeat (8) @(posedge mclk);
        rdChk("status", REG_STATUS, 32'h1);
        loopReq.loopOut <= 16'd150;
        repeat (8) @(posedge mclk);
        rdChk("status", REG_STATUS, 32'h2);
        giveVerdict();
    end
endmodule : test_pid_sleep_wakeup_pump_staging
